/* File: verilog/qdds_top.v */
// Purpose: diagnostic status and fault latching of a four-channel driver
// Assumes: host reaches registers over the 16-bit serial link
// Notes:   protection, analog sensing and other config live outside
//
// Operation
// RL1: timer register at 0x09 holds ch3 blanking in 7..4, ch2 in 3..0, resets 0.
// RL2: sense pin routed only when mux enable bit 3 set; bits 2..0 pick channel.
// RL3: sense output is high impedance whenever nothing is routed to it.
// RL4: every frame returns a global status byte showing normal or fail-safe mode.
// RL5: direct-input register is real time, one bit per input, cleared without battery.
// RL6: fault summary bit ORs overload, power limit, overtemperature; read-and-clear. Code also clears it while the channel is on with no fault.
// RL7: off-state open-load register is read-and-clear; meaning depends on pull-up.
// RL8: latch-off bit set on latch-off; host clears it by writing the timer register.
// RL9: overload register holds one read-and-clear bit per channel for high drop.
// RL10: generic bit 7 undervoltage, bit 6 reset warning, bit 5 link error.
// RL11: overload voltage judged at each turn-off; high sets the channel bit.
// RL12: overload also sets summary bit, status byte bit 4 and global error.
// RL13: overload bit only warns and holds until read-and-clear or next turn-off.
// RL14: off-state output above threshold sets open-load bit, status bit 1, inverted bit.
// RL15: open-load evaluation starts only after a fixed delay from turn-off.
// RL16: a set pull-up control bit enables that channel's pull-up source.
// RL17: pull-ups off in deep sleep, enable bits kept and resumed afterwards.
// RL18: power-on or all-ones command byte clears every register and pull-up.
// RL19: with pull-up off an open load reads 0; shorts read 1 always.
// RL20: open-load bits refresh while off, latch while on, read-and-clear then.
// RL21: blanking code zero means latch-off; each step adds 17 ms restart window.
// RL22: read-and-clear returns pre-clear value; a still active fault sets again.
`include "qdds_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module qdds_top #(
  parameter NCH        = 4,                 // number of channels
  parameter DOLOFF_CYC = `QDDS_DOLOFF_CYC   // open-load evaluation delay
) (
  input  wire           MCLK_I,             // system clock, 200 MHz
  input  wire           RESET_N_I,          // power-on reset, sync, active low
  input  wire           SCK_I,              // link clock pin
  input  wire           CSN_I,              // link select pin, active low
  input  wire           SDI_I,              // link data in pin
  output wire           SDO_O,              // link data out pin
  output wire           SDO_OE_N_O,         // low while SDO driven
  input  wire [NCH-1:0] DIRECT_IN_I,        // direct input pins
  input  wire           VBAT_OK_I,          // battery present comparator
  input  wire           UNDERVOLT_I,        // undervoltage comparator
  input  wire           FAILSAFE_I,         // device in fail-safe mode
  input  wire           DEEP_SLEEP_I,       // device in deep sleep
  input  wire           VDS_MASK_I,         // overload excluded from summary
  input  wire [NCH-1:0] CH_ON_I,            // channel output state
  input  wire [NCH-1:0] VDS_HIGH_I,         // overload comparators
  input  wire [NCH-1:0] VOUT_OL_I,          // open-load comparators
  input  wire [NCH-1:0] PWL_I,              // power limitation flags
  input  wire [NCH-1:0] OT_I,               // overtemperature flags
  input  wire [NCH-1:0] LATCHOFF_EVT_I,     // pulse: channel latched off
  output wire [NCH-1:0] PULLUP_EN_O,        // pull-up source enables
  output wire [3:0]     BLANK_CH2_O,        // ch2 blanking code
  output wire [3:0]     BLANK_CH3_O,        // ch3 blanking code
  output wire [1:0]     LATCHOFF_MODE_O,    // ch3,ch2 in latch-off mode
  output wire [NCH-1:0] LATCHOFF_CLR_O,     // pulse: re-enable channel
  output wire [2:0]     SENSE_SEL_O,        // routed sense channel
  output wire           SENSE_OE_N_O,       // low while sense pin driven
  output wire           SOFT_RESET_O        // pulse: software reset taken
);
  // ****************************************
  // declarations
  // ****************************************
  reg  [NCH-1:0] din_q0, din_q1;
  reg  [NCH-1:0] vds_q0, vds_q1;
  reg  [NCH-1:0] ol_q0, ol_q1;
  reg  [NCH-1:0] pwl_q0, pwl_q1;
  reg  [NCH-1:0] ot_q0, ot_q1;
  reg            vbat_q0, vbat_q1;
  reg            uv_q0, uv_q1;
  reg  [7:0]     blank23_r;
  reg  [7:0]     mux_r;
  reg  [NCH-1:0] pullup_r;
  reg  [NCH-1:0] loff_r;
  reg  [NCH-1:0] loff_clr_r;
  reg            rst_warn_r;
  reg            spi_err_r;
  reg            soft_rst_r;
  reg  [7:0]     rdata_r;
  reg  [7:0]     rdata_nxt;
  reg            clr_vds_r, clr_ol_r, clr_fb_r, clr_gen_r;
  wire           sw_rst;
  wire           rst_all;
  wire           cmd_vld;
  wire [7:0]     cmd;
  wire           frame_ok;
  wire [15:0]    frame;
  wire           frame_err;
  wire [NCH-1:0] vds_flag;
  wire [NCH-1:0] ol_flag;
  wire [NCH-1:0] fb_flag;
  wire [7:0]     global_status_byte;
  wire [7:0]     generic_st;
  wire [7:0]     din_st;
  wire [1:0]     op_now = cmd[7:6];
  wire [5:0]     adr_now = cmd[5:0];
  wire [1:0]     op_frm = frame[15:14];
  wire [5:0]     adr_frm = frame[13:8];
  wire [7:0]     wdat = frame[7:0];
  // software reset acts like power-on on everything but the link itself
  assign sw_rst  = frame_ok && (frame[15:8] == `QDDS_CMD_SWRESET);
  assign rst_all = !RESET_N_I || soft_rst_r;                        // RL18
  // ****************************************
  // input synchronisers, first stage read only by second
  // ****************************************
  always @(posedge MCLK_I) begin
    din_q0  <= DIRECT_IN_I;
    din_q1  <= din_q0;
    vds_q0  <= VDS_HIGH_I;
    vds_q1  <= vds_q0;
    ol_q0   <= VOUT_OL_I;
    ol_q1   <= ol_q0;
    pwl_q0  <= PWL_I;
    pwl_q1  <= pwl_q0;
    ot_q0   <= OT_I;
    ot_q1   <= ot_q0;
    vbat_q0 <= VBAT_OK_I;
    vbat_q1 <= vbat_q0;
    uv_q0   <= UNDERVOLT_I;
    uv_q1   <= uv_q0;
  end
  // ****************************************
  // serial link
  // ****************************************
  qdds_spi_link u_link (
    .clk_i       (MCLK_I),
    .rst_n_i     (RESET_N_I),
    .sck_i       (SCK_I),
    .csn_i       (CSN_I),
    .sdi_i       (SDI_I),
    .gsb_i       (global_status_byte),
    .rdata_i     (rdata_r),
    .sdo_o       (SDO_O),
    .sdo_oe_n_o  (SDO_OE_N_O),
    .cmd_vld_o   (cmd_vld),
    .cmd_o       (cmd),
    .frame_ok_o  (frame_ok),
    .frame_o     (frame),
    .frame_err_o (frame_err)
  );
  // ****************************************
  // per-channel diagnostic flags
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      qdds_chan_diag #(
        .DOLOFF_CYC (DOLOFF_CYC)
      ) u_diag (
        .clk_i      (MCLK_I),
        .rst_i      (rst_all),
        .on_i       (CH_ON_I[g]),
        .vds_high_i (vds_q1[g]),
        .vout_ol_i  (ol_q1[g]),
        .pwl_i      (pwl_q1[g]),
        .ot_i       (ot_q1[g]),
        .vds_mask_i (VDS_MASK_I),
        .clr_vds_i  (clr_vds_r),
        .clr_ol_i   (clr_ol_r),
        .clr_fb_i   (clr_fb_r),
        .vds_o      (vds_flag[g]),
        .ol_o       (ol_flag[g]),
        .fb_o       (fb_flag[g])
      );
    end
  endgenerate
  // ****************************************
  // status views
  // ****************************************
  // direct inputs read low while battery is missing
  assign din_st = {{(8-NCH){1'b0}}, din_q1 & {NCH{vbat_q1}}};      // RL5
  // undervoltage is live, the other two are sticky
  assign generic_st = {uv_q1, rst_warn_r, spi_err_r, 5'h00};        // RL10
  // global status byte, rebuilt every cycle and sampled at frame start
  assign global_status_byte[`QDDS_GSB_ERR_BIT]  = (|fb_flag) | (|ol_flag) |
                                   ((|vds_flag) & ~VDS_MASK_I) | (|loff_r); // RL12
  assign global_status_byte[`QDDS_GSB_COMM_BIT] = spi_err_r;
  assign global_status_byte[`QDDS_GSB_FS_BIT]   = FAILSAFE_I;                      // RL4
  assign global_status_byte[`QDDS_GSB_VDS_BIT]  = (|vds_flag) & ~VDS_MASK_I;       // RL12
  assign global_status_byte[`QDDS_GSB_FB_BIT]   = |fb_flag;
  assign global_status_byte[`QDDS_GSB_RST_BIT]  = rst_warn_r;
  assign global_status_byte[`QDDS_GSB_OL_BIT]   = |ol_flag;                        // RL14
  // inverted summary bit: set when any fault flag is up
  assign global_status_byte[`QDDS_GSB_NOT_BIT]  = |{fb_flag, ol_flag, vds_flag};   // RL14
  // ****************************************
  // read data mux, picked when the command byte lands
  // ****************************************
  always @* begin
    rdata_nxt = 8'h00;
    case (adr_now)
      `QDDS_OFS_PULLUP:   rdata_nxt = {{(8-NCH){1'b0}}, pullup_r};
      `QDDS_OFS_SENSEMUX: rdata_nxt = mux_r;
      `QDDS_OFS_BLANK23:  rdata_nxt = blank23_r;
      `QDDS_OFS_DIN:      rdata_nxt = din_st;
      `QDDS_OFS_FAULTSUM: rdata_nxt = {{(8-NCH){1'b0}}, fb_flag};
      `QDDS_OFS_OPENLOAD: rdata_nxt = {{(8-NCH){1'b0}}, ol_flag};
      `QDDS_OFS_LATCHOFF: rdata_nxt = {{(8-NCH){1'b0}}, loff_r};
      `QDDS_OFS_OVERLOAD: rdata_nxt = {{(8-NCH){1'b0}}, vds_flag};
      `QDDS_OFS_GENERIC:  rdata_nxt = generic_st;
      default:            rdata_nxt = 8'h00;
    endcase
  end
  // snapshot first, clear one cycle later, so the host sees pre-clear bits
  always @(posedge MCLK_I) begin
    if (rst_all) begin
      rdata_r   <= 8'h00;
      clr_vds_r <= 1'b0;
      clr_ol_r  <= 1'b0;
      clr_fb_r  <= 1'b0;
      clr_gen_r <= 1'b0;
    end else begin
      if (cmd_vld)
        rdata_r <= rdata_nxt;                                       // RL22
      clr_fb_r  <= cmd_vld && op_now == `QDDS_OP_RDCLR &&
                   adr_now == `QDDS_OFS_FAULTSUM;                   // RL6
      clr_ol_r  <= cmd_vld && op_now == `QDDS_OP_RDCLR &&
                   adr_now == `QDDS_OFS_OPENLOAD;                   // RL7
      clr_vds_r <= cmd_vld && op_now == `QDDS_OP_RDCLR &&
                   adr_now == `QDDS_OFS_OVERLOAD;                   // RL9
      clr_gen_r <= cmd_vld && op_now == `QDDS_OP_RDCLR &&
                   adr_now == `QDDS_OFS_GENERIC;                    // RL10
    end
  end
  // ****************************************
  // control registers, written at end of a good frame
  // ****************************************
  always @(posedge MCLK_I) begin
    if (rst_all) begin
      blank23_r  <= `QDDS_RST_CTRL;                                 // RL1 RL18
      mux_r      <= `QDDS_RST_CTRL;
      pullup_r   <= {NCH{1'b0}};                                    // RL18
      loff_clr_r <= {NCH{1'b0}};
    end else begin
      loff_clr_r <= {NCH{1'b0}};
      if (frame_ok && op_frm == `QDDS_OP_WRITE && !sw_rst) begin
        case (adr_frm)
          `QDDS_OFS_BLANK23: begin
            blank23_r  <= wdat;                                     // RL1
            loff_clr_r <= 4'hc;                                     // RL8
          end
          `QDDS_OFS_BLANK01: begin
            loff_clr_r <= 4'h3;                                     // RL8
          end
          `QDDS_OFS_SENSEMUX: begin
            mux_r <= {4'h0, wdat[3:0]};
          end
          `QDDS_OFS_PULLUP: begin
            pullup_r <= wdat[NCH-1:0];                              // RL16
          end
          default: begin
            mux_r <= mux_r;
          end
        endcase
      end
    end
  end
  // ****************************************
  // latch-off status: set by protection, cleared by timer write
  // ****************************************
  always @(posedge MCLK_I) begin
    if (rst_all)
      loff_r <= {NCH{1'b0}};
    else
      loff_r <= LATCHOFF_EVT_I | (loff_r & ~loff_clr_r);            // RL8
  end
  // ****************************************
  // generic warnings and software reset
  // ****************************************
  always @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      rst_warn_r <= 1'b1;                                           // RL10
      spi_err_r  <= 1'b0;
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= sw_rst;                                         // RL18
      // new events beat a read-and-clear in the same cycle
      if (soft_rst_r)
        rst_warn_r <= 1'b1;
      else if (clr_gen_r)
        rst_warn_r <= 1'b0;
      if (frame_err)
        spi_err_r <= 1'b1;
      else if (clr_gen_r || soft_rst_r)
        spi_err_r <= 1'b0;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  // enable bits survive deep sleep; only the sources drop out
  assign PULLUP_EN_O     = pullup_r & {NCH{~DEEP_SLEEP_I}};         // RL17 RL19
  assign BLANK_CH2_O     = blank23_r[3:0];
  assign BLANK_CH3_O     = blank23_r[7:4];
  // code zero selects latch-off, else 17 ms restart windows per step
  assign LATCHOFF_MODE_O = {blank23_r[7:4] == 4'h0, blank23_r[3:0] == 4'h0}; // RL21
  assign LATCHOFF_CLR_O  = loff_clr_r;
  assign SENSE_SEL_O     = mux_r[2:0];                              // RL2
  // selections past the last channel leave the pin floating
  assign SENSE_OE_N_O    = ~(mux_r[`QDDS_MUX_EN_BIT] &&
                             ({1'b0, mux_r[2:0]} < NCH[3:0]));      // RL2 RL3
  assign SOFT_RESET_O    = soft_rst_r;
endmodule // qdds_top
`default_nettype wire

/* File: common/qdds_consts.vh */
// Purpose: shared constants of the quad driver diagnostic status block
// Assumes: 200 MHz system clock, 16-bit serial frames
// Notes:   definitions only
`ifndef QDDS_CONSTS_VH
`define QDDS_CONSTS_VH
// ****************************************
// register offsets (6-bit address field)
// ****************************************
`define QDDS_OFS_PULLUP    6'h02
`define QDDS_OFS_SENSEMUX  6'h06
`define QDDS_OFS_BLANK01   6'h08
`define QDDS_OFS_BLANK23   6'h09
`define QDDS_OFS_DIN       6'h2f
`define QDDS_OFS_FAULTSUM  6'h30
`define QDDS_OFS_OPENLOAD  6'h31
`define QDDS_OFS_LATCHOFF  6'h32
`define QDDS_OFS_OVERLOAD  6'h33
`define QDDS_OFS_GENERIC   6'h34
// ****************************************
// command byte: opcode in bits 7..6
// ****************************************
`define QDDS_OP_WRITE      2'h0
`define QDDS_OP_READ       2'h1
`define QDDS_OP_RDCLR      2'h2
`define QDDS_CMD_SWRESET   8'hff
`define QDDS_FRAME_BITS    5'h10
`define QDDS_BYTE_BITS     5'h08
// ****************************************
// field positions and reset values
// ****************************************
`define QDDS_MUX_EN_BIT    3
`define QDDS_GEN_UV_BIT    7
`define QDDS_GEN_RST_BIT   6
`define QDDS_GEN_SPI_BIT   5
`define QDDS_GSB_ERR_BIT   7
`define QDDS_GSB_COMM_BIT  6
`define QDDS_GSB_FS_BIT    5
`define QDDS_GSB_VDS_BIT   4
`define QDDS_GSB_FB_BIT    3
`define QDDS_GSB_RST_BIT   2
`define QDDS_GSB_OL_BIT    1
`define QDDS_GSB_NOT_BIT   0
`define QDDS_RST_CTRL      8'h00
// ****************************************
// timing: open-load evaluation delay after turn-off
// ****************************************
`define QDDS_CLK_PERIOD_NS 5
`define QDDS_T_DOLOFF_NS   10000
`define QDDS_DOLOFF_CYC    ((`QDDS_T_DOLOFF_NS + `QDDS_CLK_PERIOD_NS - 1) / `QDDS_CLK_PERIOD_NS)
`endif

/* File: verilog/qdds_spi_link.v */
// Purpose: 16-bit serial link slave, oversampled by the system clock
// Assumes: mode 0 framing, MSB first, link clock far slower than clk_i
// Notes:   all pins pass two flops before use
`include "qdds_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module qdds_spi_link (
  input  wire        clk_i,        // system clock
  input  wire        rst_n_i,      // sync reset, active low
  input  wire        sck_i,        // link clock pin
  input  wire        csn_i,        // chip select pin, active low
  input  wire        sdi_i,        // serial data in pin
  input  wire [7:0]  gsb_i,        // status byte sent first
  input  wire [7:0]  rdata_i,      // data byte sent second
  output wire        sdo_o,        // serial data out
  output wire        sdo_oe_n_o,   // low while driving
  output reg         cmd_vld_o,    // pulse: command byte complete
  output reg  [7:0]  cmd_o,        // command byte
  output reg         frame_ok_o,   // pulse: 16-bit frame ended
  output reg  [15:0] frame_o,      // received frame
  output reg         frame_err_o   // pulse: frame of wrong length
);
  reg [2:0]  sck_q;
  reg [2:0]  csn_q;
  reg [1:0]  sdi_q;
  reg [15:0] rx_r;
  reg [15:0] tx_r;
  reg [4:0]  cnt_r;
  wire sck_rise = sck_q[1] & ~sck_q[2];
  wire sck_fall = ~sck_q[1] & sck_q[2];
  wire cs_fall  = ~csn_q[1] & csn_q[2];
  wire cs_rise  = csn_q[1] & ~csn_q[2];
  wire active   = ~csn_q[2];
  // ****************************************
  // pin synchronisers, stage 0 feeds only stage 1
  // ****************************************
  always @(posedge clk_i) begin
    sck_q <= {sck_q[1:0], sck_i};
    csn_q <= {csn_q[1:0], csn_i};
    sdi_q <= {sdi_q[0], sdi_i};
  end
  // ****************************************
  // shifting and framing
  // ****************************************
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_r <= 16'h0000; tx_r <= 16'h0000; cnt_r <= 5'h00;
      cmd_vld_o <= 1'b0; cmd_o <= 8'h00; frame_ok_o <= 1'b0;
      frame_o <= 16'h0000; frame_err_o <= 1'b0;
    end else begin
      cmd_vld_o   <= 1'b0;
      frame_ok_o  <= 1'b0;
      frame_err_o <= 1'b0;
      if (cs_fall) begin
        cnt_r <= 5'h00;
        tx_r  <= {gsb_i, 8'h00};
      end else if (active && sck_rise) begin
        rx_r  <= {rx_r[14:0], sdi_q[1]};
        cnt_r <= (cnt_r == 5'h1f) ? cnt_r : cnt_r + 5'h01;
        if (cnt_r == `QDDS_BYTE_BITS - 5'h01) begin
          cmd_vld_o <= 1'b1;
          cmd_o     <= {rx_r[6:0], sdi_q[1]};
        end
      end else if (active && sck_fall) begin
        // data byte is loaded once the command has been decoded
        tx_r <= (cnt_r == `QDDS_BYTE_BITS) ? {rdata_i, 8'h00} : {tx_r[14:0], 1'b0};
      end
      if (cs_rise) begin
        frame_o     <= rx_r;
        frame_ok_o  <= (cnt_r == `QDDS_FRAME_BITS);
        frame_err_o <= (cnt_r != `QDDS_FRAME_BITS);
      end
    end
  end
  assign sdo_o      = active ? tx_r[15] : 1'b0;
  assign sdo_oe_n_o = ~active;
endmodule // qdds_spi_link
`default_nettype wire

/* File: verilog/qdds_chan_diag.v */
// Purpose: per-channel overload, open-load and fault-summary flags
// Assumes: condition inputs already synchronised
// Notes:   sets always win over read-and-clear
`include "qdds_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module qdds_chan_diag #(
  parameter DOLOFF_CYC = `QDDS_DOLOFF_CYC
) (
  input  wire clk_i,        // system clock
  input  wire rst_i,        // sync reset, active high
  input  wire on_i,         // channel switched on
  input  wire vds_high_i,   // drain-source above overload level
  input  wire vout_ol_i,    // off-state output above open-load level
  input  wire pwl_i,        // power limitation flag
  input  wire ot_i,         // overtemperature flag
  input  wire vds_mask_i,   // mask overload from summary
  input  wire clr_vds_i,    // read-and-clear of overload reg
  input  wire clr_ol_i,     // read-and-clear of open-load reg
  input  wire clr_fb_i,     // read-and-clear of summary reg
  output reg  vds_o,        // overload flag
  output reg  ol_o,         // off-state open-load flag
  output reg  fb_o          // fault summary flag
);
  reg        on_d_r;
  reg [15:0] dly_r;
  wire off_edge = on_d_r & ~on_i;
  wire dly_done = (dly_r == DOLOFF_CYC[15:0]);
  wire fault    = pwl_i | ot_i | (vds_o & ~vds_mask_i);
  // ****************************************
  // flag update
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      on_d_r <= 1'b0; dly_r <= 16'h0000;
      vds_o <= 1'b0; ol_o <= 1'b0; fb_o <= 1'b0;
    end else begin
      on_d_r <= on_i;
      // overload judged at each turn-off, held until cleared or next turn-off
      if (off_edge)                                       // RL11 RL13
        vds_o <= vds_high_i;
      else if (clr_vds_i)
        vds_o <= 1'b0;
      // evaluation delay restarts on every turn-off
      if (on_i || off_edge)                               // RL15
        dly_r <= 16'h0000;
      else if (!dly_done)
        dly_r <= dly_r + 16'h0001;
      if (!on_i && dly_done)                              // RL14 RL20
        ol_o <= vout_ol_i;
      else if (clr_ol_i)
        ol_o <= 1'b0;
      if (fault)                                          // RL6 RL12 RL22
        fb_o <= 1'b1;
      else if (on_i || clr_fb_i)
        fb_o <= 1'b0;
    end
  end
endmodule // qdds_chan_diag
`default_nettype wire

/* File: sim/qdds_top_sva.sv */
// Purpose: port checks of qdds_top
// Assumes: one clock, sync reset
// Notes:   bound after the module
`timescale 1ns/1ps
`default_nettype none
module qdds_chk #(parameter NCH = 4, parameter DOLOFF_CYC = 20) (
  input wire logic           MCLK_I,          // clock
  input wire logic           RESET_N_I,       // reset, low
  input wire logic           CSN_I,           // link select
  input wire logic           SDO_OE_N_O,      // sdo enable, low
  input wire logic           DEEP_SLEEP_I,    // deep sleep
  input wire logic [NCH-1:0] PULLUP_EN_O,     // pull-ups
  input wire logic [3:0]     BLANK_CH2_O,     // ch2 code
  input wire logic [3:0]     BLANK_CH3_O,     // ch3 code
  input wire logic [1:0]     LATCHOFF_MODE_O, // latch-off modes
  input wire logic [NCH-1:0] LATCHOFF_CLR_O,  // clear pulses
  input wire logic [2:0]     SENSE_SEL_O,     // sense channel
  input wire logic           SENSE_OE_N_O,    // sense enable, low
  input wire logic           SOFT_RESET_O     // soft reset pulse
);
  // ******
  // properties
  // ******
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  // link quiet long enough for any write to land
  sequence s_quiet; CSN_I [*8]; endsequence
  a_sleep_gates_pullup: assert property (DEEP_SLEEP_I |-> PULLUP_EN_O == '0)
    else $error("pull-up on in deep sleep");
  a_mux_off_hiz: assert property (SENSE_SEL_O[2] |-> SENSE_OE_N_O)
    else $error("sense driven with no channel");
  a_mode_tracks_code: assert property (LATCHOFF_MODE_O == {BLANK_CH3_O == 4'h0, BLANK_CH2_O == 4'h0})
    else $error("latch-off mode differs from code");
  a_clr_one_cycle: assert property (|LATCHOFF_CLR_O |=> LATCHOFF_CLR_O == '0)
    else $error("latch-off clear longer than one cycle");
  a_clr_pairs: assert property (|LATCHOFF_CLR_O |-> LATCHOFF_CLR_O inside {4'h3, 4'hc})
    else $error("latch-off clear on wrong channels");
  a_swrst_clears: assert property (SOFT_RESET_O |=> !SOFT_RESET_O ##1 (PULLUP_EN_O == '0 && LATCHOFF_MODE_O == 2'h3 && SENSE_OE_N_O))
    else $error("soft reset left state behind");
  a_idle_released: assert property (s_quiet |-> SDO_OE_N_O)
    else $error("sdo driven while deselected");
  a_code_quiet: assert property (s_quiet |-> $stable({BLANK_CH3_O, BLANK_CH2_O}))
    else $error("blanking code moved without a frame");
endmodule // qdds_chk
bind qdds_top qdds_chk #(.NCH(NCH), .DOLOFF_CYC(DOLOFF_CYC)) u_chk (.MCLK_I, .RESET_N_I,
  .CSN_I, .SDO_OE_N_O, .DEEP_SLEEP_I, .PULLUP_EN_O, .BLANK_CH2_O, .BLANK_CH3_O,
  .LATCHOFF_MODE_O, .LATCHOFF_CLR_O, .SENSE_SEL_O, .SENSE_OE_N_O, .SOFT_RESET_O);
`default_nettype wire

/* File: sim/qdds_host.sv */
// Purpose: host side of the serial link
// Assumes: mode 0, 80 ns link period
// Notes:   link clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module qdds_host (
  input  wire logic clk_i,          // system clock
  input  wire logic sdo_i,          // data from device
  output var  logic sck_o = 1'b0,   // link clock
  output var  logic csn_n_o = 1'b1, // select, low
  output var  logic sdi_o = 1'b0    // data to device
);
  // ******
  // one frame of nbits, msb first
  // ******
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = '0;
    @(posedge clk_i) csn_n_o <= 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      sdi_o <= tx[i];
      repeat (8) @(posedge clk_i);
      sck_o <= 1'b1;
      rx = {rx[14:0], sdo_i};
      repeat (8) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
    csn_n_o <= 1'b1;
    sdi_o <= ~sdi_o; // no stale value
    repeat (8) @(posedge clk_i);
  endtask
endmodule // qdds_host
`default_nettype wire

/* File: sim/quad_driver_diagnostic_status_tb.sv */
// Purpose: register level test of qdds_top
// Assumes: open-load delay shortened to 20
// Notes:   power limit, temperature, mask tied off
`include "qdds_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module quad_driver_diagnostic_status_tb;
  logic clk = 0, rst_n = 0, vbat = 1, uv = 0, fs = 0, slp = 0;
  logic sck, csn_n, sdi, sdo;
  logic [3:0] din = 0, on = 0, vds = 0, vol = 0, evt = 0, pu, clr;
  logic [3:0] b2, b3;
  logic [2:0] sel;
  logic [1:0] lmode;
  logic soe_n, srst;
  logic [15:0] r;
  int n_fail = 0, samples_checked = 0;
  initial forever #2.5 clk = ~clk;
  qdds_host u_host (.clk_i(clk), .sdo_i(sdo), .sck_o(sck), .csn_n_o(csn_n), .sdi_o(sdi));
  qdds_top #(.DOLOFF_CYC(20)) u_dut (.MCLK_I(clk), .RESET_N_I(rst_n), .SCK_I(sck),
    .CSN_I(csn_n), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_N_O(), .DIRECT_IN_I(din),
    .VBAT_OK_I(vbat), .UNDERVOLT_I(uv), .FAILSAFE_I(fs), .DEEP_SLEEP_I(slp),
    .VDS_MASK_I(1'b0), .CH_ON_I(on), .VDS_HIGH_I(vds), .VOUT_OL_I(vol), .PWL_I(4'h0),
    .OT_I(4'h0), .LATCHOFF_EVT_I(evt), .PULLUP_EN_O(pu), .BLANK_CH2_O(b2),
    .BLANK_CH3_O(b3), .LATCHOFF_MODE_O(lmode), .LATCHOFF_CLR_O(clr),
    .SENSE_SEL_O(sel), .SENSE_OE_N_O(soe_n), .SOFT_RESET_O(srst));
  // ******
  // helpers
  // ******
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic op(input logic [1:0] o, input logic [5:0] a, input logic [7:0] d);
    u_host.xfer({o, a, d}, 16, r);
  endtask
  task report_and_stop;
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ******
  // scenarios
  // ******
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    op(`QDDS_OP_RDCLR, `QDDS_OFS_GENERIC, 0);
    chk("gsb reset", r[`QDDS_GSB_RST_BIT+8], 1);
    chk("generic", r[7:0], 8'h40);
    uv <= 1'b1;
    op(`QDDS_OP_READ, `QDDS_OFS_GENERIC, 0);
    chk("generic uv", r[7:0], 8'h80);
    uv <= 1'b0;
    op(`QDDS_OP_WRITE, `QDDS_OFS_BLANK23, 8'h5a);
    chk("blank old", r[7:0], 8'h00);
    op(`QDDS_OP_READ, `QDDS_OFS_BLANK23, 0);
    chk("blank", r[7:0], 8'h5a);
    chk("blank pins", {b3, b2}, 8'h5a);
    op(`QDDS_OP_WRITE, `QDDS_OFS_SENSEMUX, 8'h0b);
    chk("mux on", {soe_n, sel}, 4'h3);
    op(`QDDS_OP_WRITE, `QDDS_OFS_SENSEMUX, 8'h07);
    chk("mux off", {soe_n, sel}, 4'hf);
    op(`QDDS_OP_WRITE, `QDDS_OFS_PULLUP, 8'h05);
    chk("pull-up", pu, 4'h5);
    @(posedge clk) slp <= 1'b1;
    @(negedge clk) chk("sleep pull-up", pu, 4'h0);
    @(posedge clk) slp <= 1'b0;
    @(negedge clk) chk("wake pull-up", pu, 4'h5);
    din <= 4'h9;
    op(`QDDS_OP_READ, `QDDS_OFS_DIN, 0);
    chk("inputs", r[7:0], 8'h09);
    vbat <= 1'b0;
    op(`QDDS_OP_READ, `QDDS_OFS_DIN, 0);
    chk("inputs no vbat", r[7:0], 8'h00);
    vbat <= 1'b1;
    @(posedge clk) {on, vds} <= 8'h22;
    repeat (6) @(posedge clk);
    on <= 4'h0;
    repeat (6) @(posedge clk) vds <= 4'h0;
    op(`QDDS_OP_RDCLR, `QDDS_OFS_OVERLOAD, 0);
    chk("overload", r[7:0], 8'h02);
    chk("gsb overload err", {r[15], r[12]}, 2'h3);
    op(`QDDS_OP_READ, `QDDS_OFS_FAULTSUM, 0);
    chk("summary", r[7:0], 8'h02);
    op(`QDDS_OP_READ, `QDDS_OFS_OVERLOAD, 0);
    chk("overload cleared", r[7:0], 8'h00);
    vol <= 4'h1;
    op(`QDDS_OP_RDCLR, `QDDS_OFS_OPENLOAD, 0);
    chk("open-load", r[7:0], 8'h01);
    chk("gsb open-load", r[9:8], 2'h3);
    op(`QDDS_OP_READ, `QDDS_OFS_OPENLOAD, 0);
    chk("open-load again", r[7:0], 8'h01);
    @(posedge clk) evt <= 4'h4;
    @(posedge clk) evt <= 4'h0;
    op(`QDDS_OP_READ, `QDDS_OFS_LATCHOFF, 0);
    chk("latched", r[7:0], 8'h04);
    op(`QDDS_OP_WRITE, `QDDS_OFS_BLANK23, 8'h00);
    op(`QDDS_OP_READ, `QDDS_OFS_LATCHOFF, 0);
    chk("latch cleared", r[7:0], 8'h00);
    fs <= 1'b1;
    u_host.xfer(16'h4000, 12, r);
    op(`QDDS_OP_RDCLR, `QDDS_OFS_GENERIC, 0);
    chk("gsb fs link", r[14:13], 2'h3);
    chk("generic link", r[7:0], 8'h20);
    fs <= 1'b0;
    u_host.xfer(16'hff00, 16, r);
    op(`QDDS_OP_READ, `QDDS_OFS_PULLUP, 0);
    chk("soft reset", {pu, r[7:0]}, 12'h000);
    report_and_stop();
  end
endmodule // quad_driver_diagnostic_status_tb
`default_nettype wire
